// [rtl/rrs_params.svh]
`ifndef RRS_PARAMS_SVH
`define RRS_PARAMS_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define RRS_CLK_HZ 50000000
`define RRS_TICK_MS 100
`define RRS_BTN_TIMEOUT_MS 5000
// ----------------------------------------
// configuration limits, in 100 ms units
// ----------------------------------------
`define RRS_CFG_MIN 8'h01
`define RRS_CFG_MAX 8'hFF
// ----------------------------------------
// batch limits and buffering
// ----------------------------------------
`define RRS_BATCH_MAX 6'h20
`define RRS_CHAR_LIMIT 16'h2710
`define RRS_FIFO_DEPTH 16
// ----------------------------------------
// result word layout: {kind, pass, symbology, key, length}
// ----------------------------------------
`define RRS_LEN_W 14
`define RRS_KEY_W 32
`define RRS_SYM_W 8
`define RRS_WORD_W 57
`define RRS_KIND_LSB 55
`define RRS_PASS_BIT 54
`define RRS_SYM_LSB 46
`define RRS_KEY_LSB 14
`endif

// [rtl/rrs_pkg.sv]
package rrs_pkg;
   typedef enum logic [1:0] {RRS_MODE_SINGLE, RRS_MODE_SEQ, RRS_MODE_BATCH} rrs_mode_t;
   typedef enum logic [1:0] {RRS_SRC_BUTTON, RRS_SRC_TRIG, RRS_SRC_CMD} rrs_src_t;
   typedef enum logic [1:0] {RRS_KIND_RESULT, RRS_KIND_FAIL, RRS_KIND_BATCH_END} rrs_kind_t;
   typedef enum {RRS_ST_IDLE, RRS_ST_READ, RRS_ST_FINISH} rrs_state_t;
endpackage

// [rtl/rrs_fifo.sv]
`timescale 1ns/100ps
module rrs_fifo #(
   parameter int unsigned WIDTH = 57,
   parameter int unsigned DEPTH = 16
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] cnt;
   logic do_push;
   logic do_pop;

   // read data sit in a register, so the consumer sees flop outputs
   assign in_ready_o = (cnt != DEPTH[AW:0]);
   assign do_push = in_valid_i && in_ready_o;
   assign do_pop = (cnt != '0) && (!out_valid_o || out_ready_i);
   assign level_o = cnt;

   always_ff @(posedge ref_clk_i)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         cnt <= cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end
      else if (do_pop)
      begin
         out_valid_o <= 1'b1;
         out_data_o <= mem[rd_ptr];
      end
      else if (out_ready_i)
      begin
         out_valid_o <= 1'b0;
      end
   end
endmodule

// [rtl/rrs_seq.sv]
// Notes on behaviour
// - sequential multi-read: read while request held
// - infinite timeout means level, finite means edge
// - duplicate window accepted only inside range
// - drop same symbology and data in window
// - sequential: resume only after prior result drained
// - release before any symbol reports failure
// - orange lamp on at start, off later
// - green or red on at stop, off later
// - classify pass or verify match at stop
// - batch: pass each result on as read, end record at stop
// - batch keeps at most 32 results
// - batch character total flagged at limit
// - batch outputs follow final result only
// - single edge trigger: stop on success, timeout
// - multi edge trigger ends only on timeout
// - level trigger: read only while held
// - commands start and stop a session
// - button forces single edge 5 s read
// - command request clears after reading stops
`timescale 1ns/100ps
`include "rrs_params.svh"
module rrs_seq import rrs_pkg::*; #(
   parameter int unsigned TICK_CYCLES = `RRS_CLK_HZ / 1000 * `RRS_TICK_MS
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic button_i,
   input wire logic trig_i,
   input wire logic cmd_start_i,
   input wire logic cmd_stop_i,
   input wire logic [1:0] read_mode_i,
   input wire logic timeout_inf_i,
   input wire logic [7:0] timeout_cfg_i,
   input wire logic [7:0] dup_win_cfg_i,
   input wire logic lamp_link_en_i,
   input wire logic [7:0] lamp_hold_cfg_i,
   input wire logic verify_en_i,
   input wire logic sym_valid_i,
   output logic sym_ready_o,
   input wire logic [`RRS_SYM_W-1:0] sym_type_i,
   input wire logic [`RRS_KEY_W-1:0] sym_key_i,
   input wire logic [`RRS_LEN_W-1:0] sym_len_i,
   input wire logic sym_ok_i,
   output logic res_valid_o,
   input wire logic res_ready_i,
   output logic [`RRS_WORD_W-1:0] res_data_o,
   output logic reading_o,
   output logic read_req_o,
   output logic lamp_orange_o,
   output logic lamp_green_o,
   output logic lamp_red_o,
   output logic ext_out_o,
   output logic batch_over_o
);
   localparam logic [7:0] BTN_TICKS = 8'(`RRS_BTN_TIMEOUT_MS / `RRS_TICK_MS);
   localparam logic [4:0] FIFO_ROOM = 5'(`RRS_FIFO_DEPTH - 2);

   function automatic logic is_multi(input rrs_mode_t m);
      is_multi = (m != RRS_MODE_SINGLE);
   endfunction

   // ----------------------------------------
   // inputs, timebase, configuration
   // ----------------------------------------
   logic trig_meta, trig_sync, trig_prev, btn_prev;
   logic trig_rise, btn_rise, start_req;
   logic [31:0] tick_cnt;
   logic tick;
   logic [7:0] tmo_cfg, dup_cfg;

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
         btn_prev <= 1'b0;
      end
      else
      begin
         trig_meta <= trig_i;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
         btn_prev <= button_i;
      end
   end
   assign trig_rise = trig_sync && !trig_prev;
   assign btn_rise = button_i && !btn_prev;
   assign start_req = btn_rise || trig_rise || cmd_start_i;

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || tick)
      begin
         tick_cnt <= '0;
      end
      else
      begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

   // out-of-range settings are refused, the last good one stays
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         tmo_cfg <= `RRS_CFG_MAX;
         dup_cfg <= `RRS_CFG_MIN;
      end
      else
      begin
         if (timeout_cfg_i >= `RRS_CFG_MIN)
         begin
            tmo_cfg <= timeout_cfg_i;
         end
         if (dup_win_cfg_i >= `RRS_CFG_MIN && dup_win_cfg_i <= `RRS_CFG_MAX)
         begin
            dup_cfg <= dup_win_cfg_i;
         end
      end
   end

   // ----------------------------------------
   // session control
   // ----------------------------------------
   rrs_state_t st;
   rrs_src_t src;
   rrs_mode_t eff_mode;
   logic eff_edge, got, last_ok, take, is_dup, tmo_exp, stop_cond, pass_now;
   logic [7:0] tmo_left, dup_left;
   logic [5:0] batch_cnt;
   logic [15:0] char_sum;
   logic [`RRS_SYM_W-1:0] last_type;
   logic [`RRS_KEY_W-1:0] last_key;
   logic fifo_in_ready, push;
   logic [4:0] fifo_level;
   logic [`RRS_WORD_W-1:0] push_word;
   rrs_kind_t rec_kind;

   assign is_dup = is_multi(eff_mode) && dup_left != 8'h00 && sym_type_i == last_type
                   && sym_key_i == last_key;
   assign take = st == RRS_ST_READ && sym_valid_i && sym_ready_o && !is_dup
                 && !(eff_mode == RRS_MODE_BATCH && batch_cnt == `RRS_BATCH_MAX);
   assign tmo_exp = eff_edge && tick && tmo_left == 8'h01;
   assign stop_cond = st == RRS_ST_READ && (
                      (eff_mode == RRS_MODE_SINGLE && take)
                      || tmo_exp
                      || (src == RRS_SRC_CMD && cmd_stop_i)
                      || (src == RRS_SRC_TRIG && !eff_edge && !trig_sync));
   assign pass_now = (got || take)
                     && (!verify_en_i || (take ? sym_ok_i : last_ok));

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         st <= RRS_ST_IDLE;
         src <= RRS_SRC_BUTTON;
         eff_mode <= RRS_MODE_SINGLE;
         eff_edge <= 1'b1;
         tmo_left <= 8'h00;
      end
      else
      begin
         case (st)
            RRS_ST_IDLE:
            begin
               if (start_req)
               begin
                  st <= RRS_ST_READ;
                  if (btn_rise)
                  begin
                     src <= RRS_SRC_BUTTON;
                     eff_mode <= RRS_MODE_SINGLE;
                     eff_edge <= 1'b1;
                     tmo_left <= BTN_TICKS;
                  end
                  else
                  begin
                     src <= trig_rise ? RRS_SRC_TRIG : RRS_SRC_CMD;
                     eff_mode <= rrs_mode_t'(read_mode_i);
                     eff_edge <= !timeout_inf_i;
                     tmo_left <= tmo_cfg;
                  end
               end
            end
            RRS_ST_READ:
            begin
               if (stop_cond)
               begin
                  st <= RRS_ST_FINISH;
               end
               else if (tick && tmo_left != 8'h00)
               begin
                  tmo_left <= tmo_left - 8'h01;
               end
            end
            RRS_ST_FINISH:
            begin
               if (fifo_in_ready)
               begin
                  st <= RRS_ST_IDLE;
               end
            end
            default:
            begin
               st <= RRS_ST_IDLE;
            end
         endcase
      end
   end

   // per-session bookkeeping of results
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || (st == RRS_ST_IDLE && start_req))
      begin
         got <= 1'b0;
         last_ok <= 1'b0;
         batch_cnt <= '0;
         char_sum <= '0;
         batch_over_o <= 1'b0;
      end
      else if (take)
      begin
         got <= 1'b1;
         last_ok <= sym_ok_i;
         batch_cnt <= batch_cnt + 6'h01;
         char_sum <= char_sum + {2'b00, sym_len_i};
         // past the limit the formatter may mangle the batch; flag only
         if (eff_mode == RRS_MODE_BATCH && char_sum + {2'b00, sym_len_i} >= `RRS_CHAR_LIMIT)
         begin
            batch_over_o <= 1'b1;
         end
      end
   end

   // the window restarts on every accepted symbol, surviving across sessions
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         dup_left <= 8'h00;
         last_type <= '0;
         last_key <= '0;
      end
      else if (take)
      begin
         dup_left <= dup_cfg;
         last_type <= sym_type_i;
         last_key <= sym_key_i;
      end
      else if (tick && dup_left != 8'h00)
      begin
         dup_left <= dup_left - 8'h01;
      end
   end

   // ----------------------------------------
   // result stream
   // ----------------------------------------
   assign rec_kind = got ? RRS_KIND_BATCH_END : RRS_KIND_FAIL;
   assign push = take || (st == RRS_ST_FINISH && fifo_in_ready
                 && (!got || eff_mode == RRS_MODE_BATCH));
   assign push_word = take
      ? {RRS_KIND_RESULT, sym_ok_i, sym_type_i, sym_key_i, sym_len_i}
      : {rec_kind, last_ok, {`RRS_SYM_W{1'b0}}, 26'h000_0000, batch_cnt, char_sum[13:0]};

   rrs_fifo #(
      .WIDTH(`RRS_WORD_W),
      .DEPTH(`RRS_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(push_word),
      .out_valid_o(res_valid_o),
      .out_ready_i(res_ready_i),
      .out_data_o(res_data_o),
      .level_o(fifo_level)
   );

   // registered ready keeps two words of headroom for the lag
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         sym_ready_o <= 1'b0;
      end
      else
      begin
         sym_ready_o <= st == RRS_ST_READ && !stop_cond && fifo_level <= FIFO_ROOM
            && !(eff_mode == RRS_MODE_SEQ && (fifo_level != 5'h00 || res_valid_o)
                 || take && eff_mode == RRS_MODE_SEQ);
      end
   end

   // ----------------------------------------
   // request, lamps and external output
   // ----------------------------------------
   logic [7:0] lamp_left;

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         reading_o <= 1'b0;
         read_req_o <= 1'b0;
         ext_out_o <= 1'b0;
      end
      else if (st == RRS_ST_IDLE && start_req)
      begin
         reading_o <= 1'b1;
         read_req_o <= 1'b1;
         ext_out_o <= 1'b0;
      end
      else if (stop_cond)
      begin
         reading_o <= 1'b0;
         read_req_o <= 1'b0;
         ext_out_o <= pass_now;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         lamp_orange_o <= 1'b0;
         lamp_green_o <= 1'b0;
         lamp_red_o <= 1'b0;
         lamp_left <= 8'h00;
      end
      else if (!lamp_link_en_i)
      begin
         lamp_orange_o <= reading_o;
         lamp_green_o <= 1'b0;
         lamp_red_o <= 1'b0;
         lamp_left <= 8'h00;
      end
      else if (st == RRS_ST_IDLE && start_req)
      begin
         lamp_orange_o <= 1'b1;
         lamp_green_o <= 1'b0;
         lamp_red_o <= 1'b0;
         lamp_left <= lamp_hold_cfg_i;
      end
      else if (stop_cond)
      begin
         lamp_orange_o <= 1'b0;
         lamp_green_o <= pass_now;
         lamp_red_o <= !pass_now;
         lamp_left <= lamp_hold_cfg_i;
      end
      else if (tick && lamp_left != 8'h00)
      begin
         lamp_left <= lamp_left - 8'h01;
         if (lamp_left == 8'h01)
         begin
            lamp_orange_o <= 1'b0;
            lamp_green_o <= 1'b0;
            lamp_red_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_seq_release_stop: assert property (
      st == RRS_ST_READ && eff_mode == RRS_MODE_SEQ && src == RRS_SRC_TRIG && !eff_edge
      && !trig_sync |=> st == RRS_ST_FINISH ##1 !reading_o)
      else $error("sequential read did not stop on release");
   a_edge_from_timeout: assert property (
      st == RRS_ST_IDLE && start_req && !btn_rise |=> eff_edge == !$past(timeout_inf_i))
      else $error("activation kind does not follow timeout setting");
   a_dup_cfg_range: assert property (
      dup_cfg >= `RRS_CFG_MIN)
      else $error("duplicate window outside range");
   a_dup_dropped: assert property (
      st == RRS_ST_READ && sym_valid_i && sym_ready_o && is_dup |=> $stable(batch_cnt))
      else $error("duplicate symbol was counted");
   a_seq_wait_drain: assert property (
      st == RRS_ST_READ && eff_mode == RRS_MODE_SEQ && res_valid_o |=> !sym_ready_o)
      else $error("sequential read resumed before result drained");
   a_fail_record: assert property (
      st == RRS_ST_FINISH && !got && fifo_in_ready |-> push
      && push_word[`RRS_WORD_W-1:`RRS_KIND_LSB] == RRS_KIND_FAIL)
      else $error("empty session not reported as failure");
   a_orange_start: assert property (
      lamp_link_en_i && st == RRS_ST_IDLE && start_req |=> lamp_orange_o && !lamp_green_o)
      else $error("orange lamp not lit at read start");
   a_result_lamp: assert property (
      lamp_link_en_i && stop_cond |=> !lamp_orange_o && (lamp_green_o != lamp_red_o)
      && lamp_green_o == ext_out_o)
      else $error("result lamp wrong at read stop");
   a_batch_cap: assert property (
      st == RRS_ST_READ && batch_cnt == `RRS_BATCH_MAX && eff_mode == RRS_MODE_BATCH
      |=> batch_cnt == `RRS_BATCH_MAX)
      else $error("batch kept more than its limit");
   a_button_single: assert property (
      st == RRS_ST_IDLE && btn_rise |=> eff_mode == RRS_MODE_SINGLE && eff_edge
      && tmo_left == BTN_TICKS)
      else $error("button did not force single edge read");
   a_multi_edge_hold: assert property (
      st == RRS_ST_READ && src == RRS_SRC_TRIG && eff_edge && is_multi(eff_mode) && !tmo_exp
      |=> st == RRS_ST_READ)
      else $error("edge multi-read ended before timeout");
   a_req_clear: assert property (
      stop_cond |=> !read_req_o [*2])
      else $error("request not cleared after stop");

   c_single_ok: cover property (eff_mode == RRS_MODE_SINGLE && take ##1 lamp_green_o);
   c_seq_fail: cover property (eff_mode == RRS_MODE_SEQ && stop_cond && !got);
   c_batch_end: cover property (push && push_word[`RRS_WORD_W-1:`RRS_KIND_LSB] == RRS_KIND_BATCH_END);
   c_cmd_stop: cover property (st == RRS_ST_READ && src == RRS_SRC_CMD && cmd_stop_i);
endmodule

// [tb/rrs_ctrl_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// external controller: trigger line and command link
// ----------------------------------------
// one request source per session, never mixed
module rrs_ctrl_model (
   input wire logic ref_clk_i,
   output logic trig_o,
   output logic cmd_start_o,
   output logic cmd_stop_o
);
   initial
   begin
      trig_o = 1'b0;
      cmd_start_o = 1'b0;
      cmd_stop_o = 1'b0;
   end

   // level held by the caller; the device sees it through its own sync
   task automatic set_trig(input logic v);
      @(posedge ref_clk_i);
      trig_o <= v;
   endtask

   // one-cycle command pulse
   task automatic pulse(input logic stop);
      @(posedge ref_clk_i);
      if (stop)
         cmd_stop_o <= 1'b1;
      else
         cmd_start_o <= 1'b1;
      @(posedge ref_clk_i);
      cmd_start_o <= 1'b0;
      cmd_stop_o <= 1'b0;
   endtask
endmodule

// [tb/test_read_request_sequencer.sv]
`timescale 1ns/100ps
`include "rrs_params.svh"
module test_read_request_sequencer import rrs_pkg::*;;
   localparam int TICK = 10;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i, button_i, sym_valid_i, sym_ok_i, res_ready_i;
   logic timeout_inf_i, lamp_link_en_i, verify_en_i;
   logic [1:0] read_mode_i;
   logic [7:0] timeout_cfg_i, dup_win_cfg_i, lamp_hold_cfg_i, sym_type_i;
   logic [31:0] sym_key_i;
   logic [13:0] sym_len_i;
   wire logic trig_i, cmd_start_i, cmd_stop_i;
   logic sym_ready_o, res_valid_o, reading_o, read_req_o, ext_out_o, batch_over_o;
   logic lamp_orange_o, lamp_green_o, lamp_red_o;
   logic [56:0] res_data_o;
   logic [56:0] q[$];
   logic [56:0] w;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;

   always #10 ref_clk_i = ~ref_clk_i;

   rrs_ctrl_model i_ctrl (.ref_clk_i, .trig_o(trig_i), .cmd_start_o(cmd_start_i),
      .cmd_stop_o(cmd_stop_i));

   rrs_seq #(.TICK_CYCLES(TICK)) i_dut (.ref_clk_i, .sys_rst_i, .button_i, .trig_i,
      .cmd_start_i, .cmd_stop_i, .read_mode_i, .timeout_inf_i, .timeout_cfg_i, .dup_win_cfg_i,
      .lamp_link_en_i, .lamp_hold_cfg_i, .verify_en_i, .sym_valid_i, .sym_ready_o, .sym_type_i,
      .sym_key_i, .sym_len_i, .sym_ok_i, .res_valid_o, .res_ready_i, .res_data_o, .reading_o,
      .read_req_o, .lamp_orange_o, .lamp_green_o, .lamp_red_o, .ext_out_o, .batch_over_o);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   always @(posedge ref_clk_i)
      if (res_valid_o === 1'b1 && res_ready_i === 1'b1)
         q.push_back(res_data_o);

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge ref_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic wait_read(input logic v, input int lim);
      for (int i = 0; i < lim && reading_o !== v; i++)
         @(posedge ref_clk_i);
      check("reading", reading_o, v);
   endtask

   function automatic logic [56:0] word(input logic [1:0] kd, input logic p,
      input logic [7:0] t, input logic [31:0] k, input logic [13:0] n);
      return {kd, p, t, k, n};
   endfunction

   task automatic take_rec(output logic [56:0] r);
      for (int i = 0; i < 100 && q.size() == 0; i++)
         @(posedge ref_clk_i);
      check("record_present", q.size() != 0, 1'b1);
      r = (q.size() != 0) ? q.pop_front() : '0;
   endtask

   // released decoder lines show the inverse, except the length, which keeps its last value
   task automatic send_sym(input logic [7:0] t, input logic [31:0] k, input logic [13:0] n,
      input logic ok);
      @(posedge ref_clk_i);
      sym_valid_i <= 1'b1;
      sym_type_i <= t;
      sym_key_i <= k;
      sym_len_i <= n;
      sym_ok_i <= ok;
      for (int i = 0; i < 200; i++)
      begin
         @(posedge ref_clk_i);
         if (sym_ready_o === 1'b1)
            break;
      end
      check("sym_taken", sym_ready_o, 1'b1);
      sym_valid_i <= 1'b0;
      sym_type_i <= ~t;
      sym_key_i <= ~k;
      sym_ok_i <= ~ok;
   endtask

   task automatic set_cfg(input rrs_mode_t m, input logic inf);
      @(posedge ref_clk_i);
      read_mode_i <= m;
      timeout_inf_i <= inf;
      q.delete();
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_cmd_single();
      set_cfg(RRS_MODE_SINGLE, 1'b0);
      i_ctrl.pulse(1'b0);
      wait_read(1'b1, 10);
      check("orange_on", lamp_orange_o, 1'b1);
      check("req_on", read_req_o, 1'b1);
      send_sym(8'h11, 32'h0000_0101, 14'h0005, 1'b1);
      wait_read(1'b0, 10);
      tick(2);
      check("req_clear", read_req_o, 1'b0);
      check("orange_off", lamp_orange_o, 1'b0);
      check("green_on", lamp_green_o, 1'b1);
      check("ext_pass", ext_out_o, 1'b1);
      take_rec(w);
      check("result", w, word(2'h0, 1'b1, 8'h11, 32'h0000_0101, 14'h0005));
   endtask

   task automatic t_trig_timeout();
      set_cfg(RRS_MODE_SINGLE, 1'b0);
      i_ctrl.set_trig(1'b1);
      tick(2);
      check("sync_delay", reading_o, 1'b0);
      wait_read(1'b1, 10);
      check("green_off", lamp_green_o, 1'b0);
      tick(15);
      check("edge_running", reading_o, 1'b1);
      wait_read(1'b0, 40);
      tick(2);
      check("red_on", lamp_red_o, 1'b1);
      take_rec(w);
      check("fail_kind", w[`RRS_KIND_LSB+:2], 2'h1);
      tick(10);
      check("no_restart", reading_o, 1'b0);
      i_ctrl.set_trig(1'b0);
      tick(5);
   endtask

   // decoder held off while a result waits, duplicates dropped
   task automatic t_seq_level();
      set_cfg(RRS_MODE_SEQ, 1'b1);
      res_ready_i <= 1'b0;
      // zero is refused, so the earlier window must still drop the repeat
      dup_win_cfg_i <= 8'h00;
      i_ctrl.set_trig(1'b1);
      wait_read(1'b1, 10);
      send_sym(8'h22, 32'h0000_0A0A, 14'h0003, 1'b1);
      tick(20);
      check("seq_hold", sym_ready_o, 1'b0);
      res_ready_i <= 1'b1;
      send_sym(8'h22, 32'h0000_0A0A, 14'h0003, 1'b1);
      send_sym(8'h22, 32'h0000_0B0B, 14'h0004, 1'b1);
      send_sym(8'h23, 32'h0000_0B0B, 14'h0006, 1'b1);
      tick(5);
      check("seq_running", reading_o, 1'b1);
      i_ctrl.set_trig(1'b0);
      wait_read(1'b0, 10);
      tick(5);
      check("seq_count", q.size(), 3);
      take_rec(w);
      check("seq_a", w, word(2'h0, 1'b1, 8'h22, 32'h0000_0A0A, 14'h0003));
      take_rec(w);
      check("seq_b", w, word(2'h0, 1'b1, 8'h22, 32'h0000_0B0B, 14'h0004));
      take_rec(w);
      check("seq_c", w, word(2'h0, 1'b1, 8'h23, 32'h0000_0B0B, 14'h0006));
   endtask

   task automatic t_cmd_stop_fail();
      set_cfg(RRS_MODE_SEQ, 1'b1);
      i_ctrl.pulse(1'b0);
      wait_read(1'b1, 10);
      tick(30);
      i_ctrl.pulse(1'b1);
      wait_read(1'b0, 10);
      tick(2);
      check("req_clear", read_req_o, 1'b0);
      take_rec(w);
      check("fail_kind", w[`RRS_KIND_LSB+:2], 2'h1);
   endtask

   // zero timeout is refused; unlinked lamps: orange mirrors reading only
   task automatic t_multi_edge();
      set_cfg(RRS_MODE_SEQ, 1'b0);
      timeout_cfg_i <= 8'h00;
      lamp_link_en_i <= 1'b0;
      i_ctrl.set_trig(1'b1);
      wait_read(1'b1, 10);
      i_ctrl.set_trig(1'b0);
      tick(15);
      check("edge_hold", reading_o, 1'b1);
      check("unlinked_orange", lamp_orange_o, 1'b1);
      wait_read(1'b0, 40);
      tick(5);
      check("unlinked_orange_off", lamp_orange_o, 1'b0);
      check("unlinked_red", lamp_red_o, 1'b0);
      lamp_link_en_i <= 1'b1;
   endtask

   task automatic t_batch();
      set_cfg(RRS_MODE_BATCH, 1'b1);
      verify_en_i <= 1'b1;
      i_ctrl.pulse(1'b0);
      wait_read(1'b1, 10);
      for (int i = 0; i < 33; i++)
         send_sym(8'h30, 32'h0000_1000 + i, 14'h0190, i < 31);
      i_ctrl.pulse(1'b1);
      wait_read(1'b0, 10);
      tick(10);
      check("batch_count", q.size(), 33);
      check("first_kind", q[0][`RRS_KIND_LSB+:2], 2'h0);
      check("end_kind", q[32][`RRS_KIND_LSB+:2], 2'h2);
      check("end_count", q[32][19:14], 6'h20);
      check("char_over", batch_over_o, 1'b1);
      check("ext_final", ext_out_o, 1'b0);
      check("red_final", lamp_red_o, 1'b1);
      verify_en_i <= 1'b0;
   endtask

   // a two-tick lamp hold must put the result lamp out again
   task automatic t_button();
      set_cfg(RRS_MODE_BATCH, 1'b1);
      lamp_hold_cfg_i <= 8'h02;
      button_i <= 1'b1;
      tick(2);
      button_i <= 1'b0;
      wait_read(1'b1, 10);
      send_sym(8'h40, 32'h0000_2222, 14'h0007, 1'b1);
      wait_read(1'b0, 10);
      tick(5);
      check("btn_count", q.size(), 1);
      check("btn_pass", ext_out_o, 1'b1);
      check("btn_green", lamp_green_o, 1'b1);
      tick(30);
      check("btn_green_off", lamp_green_o, 1'b0);
      check("btn_orange_off", lamp_orange_o, 1'b0);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      sys_rst_i = 1'b1;
      button_i = 1'b0;
      sym_valid_i = 1'b0;
      sym_ok_i = 1'b0;
      res_ready_i = 1'b1;
      timeout_inf_i = 1'b0;
      lamp_link_en_i = 1'b1;
      verify_en_i = 1'b0;
      read_mode_i = 2'h0;
      timeout_cfg_i = 8'h03;
      dup_win_cfg_i = 8'h08;
      lamp_hold_cfg_i = 8'h00;
      sym_type_i = 8'h00;
      sym_key_i = 32'h0000_0000;
      sym_len_i = 14'h0000;
      tick(16);
      sys_rst_i <= 1'b0;
      tick(3);
      t_cmd_single();
      t_trig_timeout();
      t_seq_level();
      t_cmd_stop_fail();
      t_multi_edge();
      t_batch();
      t_button();
      conclude();
   end
endmodule
